//--- pkg/cise_map.vh
// Field positions, encodings and constants of the sysreg enable / ack block
`ifndef CISE_MAP_VH
`define CISE_MAP_VH

// ----------------------------------------------------------------------
// Hypervisor enable register fields
// ----------------------------------------------------------------------
`define CISE_HSRE_SRE 0
`define CISE_HSRE_DFB 1
`define CISE_HSRE_DIB 2
`define CISE_HSRE_EN 3
`define CISE_HSRE_W 4
`define CISE_HSRE_RST 4'h0

// ----------------------------------------------------------------------
// Access encodings and levels
// ----------------------------------------------------------------------
`define CISE_ENC_NONE 2'h0
`define CISE_ENC_HSRE 2'h1
`define CISE_ENC_IAR0 2'h2
`define CISE_ENC_EL1SRE 2'h3
`define CISE_LVL_EL0 2'h0
`define CISE_LVL_EL1 2'h1
`define CISE_LVL_EL2 2'h2
`define CISE_LVL_EL3 2'h3

// ----------------------------------------------------------------------
// Acknowledge word
// ----------------------------------------------------------------------
`define CISE_ID_W 24
`define CISE_ID_NARROW 16
`define CISE_ID_SPUR_SEC 24'h0003fc
`define CISE_ID_SPUR_NS 24'h0003fd
`define CISE_ID_SPUR 24'h0003ff
`define CISE_WHY_NONE 2'h0
`define CISE_WHY_SEC 2'h1
`define CISE_WHY_NS 2'h2

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CISE_SYNC_MASKED 2'h2
`define CISE_SYNC_OPEN 2'h1

`endif

//--- rtl/cise_ack_fmt.v
// Acknowledge word formatter with registered read data
`timescale 1ns/1ps
`include "cise_map.vh"

module cise_ack_fmt #(
    parameter ID_BITS = 24
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_n_i,
    // Load strobe and raw id
    input wire load_i,
    input wire [`CISE_ID_W-1:0] id_i,
    // Formatted word
    output reg [31:0] word_q
);

    // ------------------------------------------------------------------
    // Mask unimplemented id bits
    // ------------------------------------------------------------------
    wire [`CISE_ID_W-1:0] id_m;

    genvar gi;
    generate
        for (gi = 0; gi < `CISE_ID_W; gi = gi + 1) begin : g_bit
            assign id_m[gi] = (gi < ID_BITS) ? id_i[gi] : 1'b0;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Register
    // ------------------------------------------------------------------
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_q <= 32'h00000000;
        end else if (load_i) begin
            word_q <= {8'h00, id_m};
        end
    end

endmodule

//--- rtl/cise_top.v
// Hypervisor sysreg enable register and group 0 acknowledge read path
`timescale 1ns/1ps
`include "cise_map.vh"

module cise_top #(
    parameter HAS_EL3 = 1,
    parameter IRQ_BYPASS = 1,
    parameter FIQ_BYPASS = 1,
    parameter SRE_ONLY = 0,
    parameter ID_BITS = 24
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire rst_n_i,
    // Access request from the core
    input wire req_i,
    input wire req_write_i,
    input wire [1:0] req_enc_i,
    input wire [1:0] req_level_i,
    input wire req_nonsecure_i,
    input wire req_monitor_mode_i,
    input wire [31:0] req_wdata_i,
    // Core state
    input wire pe_irq_masked_i,
    input wire top_level_a64_i,
    // Control bits held elsewhere
    input wire security_disable_ctl_i,
    input wire hyp_fiq_route_ctl_i,
    input wire hyp_coproc_trap_ctl_i,
    input wire trap_all_group0_ctl_i,
    input wire monitor_fiq_route_ctl_i,
    input wire [3:0] monitor_sysreg_enable_reg_i,
    input wire top_level_enable_i,
    input wire [3:0] el1_sysreg_enable_reg_i,
    // Highest pending group 0 interrupt
    input wire pend_valid_i,
    input wire [1:0] pend_why_i,
    input wire [`CISE_ID_W-1:0] pend_id_i,
    // Response to the core
    output reg req_ready_o,
    output reg resp_valid_o,
    output reg [31:0] resp_rdata_o,
    output reg resp_undef_o,
    output reg resp_trap_el2_o,
    output reg resp_trap_el3_o,
    output reg resp_virtual_o,
    // Acknowledge to the priority logic
    output reg ack_o,
    output reg [`CISE_ID_W-1:0] ack_id_o,
    // Write-through of bypass bits to monitor copy
    output reg mon_bypass_we_o,
    output reg [1:0] mon_bypass_wdata_o,
    // Effective controls
    output reg irq_bypass_disable_o,
    output reg fiq_bypass_disable_o,
    output reg sysreg_interface_select_o,
    output reg el1_enable_trap_o
);

    // ------------------------------------------------------------------
    // States
    // ------------------------------------------------------------------
    localparam S_IDLE = 4'b0001;
    localparam S_EVAL = 4'b0010;
    localparam S_SYNC = 4'b0100;
    localparam S_RESP = 4'b1000;

    reg [3:0] state_q;
    reg [3:0] state_d;
    reg req_write_q;
    reg [1:0] req_enc_q;
    reg [1:0] req_level_q;
    reg req_ns_q;
    reg req_mon_q;
    reg [31:0] req_wdata_q;
    reg [1:0] sync_cnt_q;

    // Hypervisor enable register storage
    reg [`CISE_HSRE_W-1:0] hsre_q;

    // ------------------------------------------------------------------
    // Register read view
    // ------------------------------------------------------------------
    wire dib_rd;
    wire dfb_rd;
    wire sre_rd;
    wire [31:0] hsre_rd;

    assign dib_rd = (IRQ_BYPASS == 0) ? 1'b1 :
        (HAS_EL3 != 0) ? monitor_sysreg_enable_reg_i[`CISE_HSRE_DIB] :
        hsre_q[`CISE_HSRE_DIB];
    assign dfb_rd = (FIQ_BYPASS == 0) ? 1'b1 :
        (HAS_EL3 != 0) ? monitor_sysreg_enable_reg_i[`CISE_HSRE_DFB] :
        hsre_q[`CISE_HSRE_DFB];
    assign sre_rd = (SRE_ONLY != 0) ? 1'b1 : hsre_q[`CISE_HSRE_SRE];
    assign hsre_rd = {28'h0000000, hsre_q[`CISE_HSRE_EN], dib_rd, dfb_rd, sre_rd};

    // Enable bit behaves as one while select is zero
    wire en_eff;
    assign en_eff = hsre_q[`CISE_HSRE_EN] | ~sre_rd;

    // ------------------------------------------------------------------
    // Access decision
    // ------------------------------------------------------------------
    reg dec_undef;
    reg dec_trap2;
    reg dec_trap3;
    reg dec_virt;
    wire a32_top;
    wire ns_el1;

    assign a32_top = (HAS_EL3 != 0) && !top_level_a64_i;
    assign ns_el1 = (req_level_q == `CISE_LVL_EL1) && req_ns_q;

    always @* begin
        dec_undef = 1'b0;
        dec_trap2 = 1'b0;
        dec_trap3 = 1'b0;
        dec_virt = 1'b0;
        case (req_enc_q)
            `CISE_ENC_HSRE: begin
                if (req_level_q == `CISE_LVL_EL1 || req_level_q == `CISE_LVL_EL0) begin
                    if (ns_el1 && hyp_coproc_trap_ctl_i) begin
                        dec_trap2 = 1'b1;
                    end else begin
                        dec_undef = 1'b1;
                    end
                end else if (req_level_q == `CISE_LVL_EL2 && HAS_EL3 != 0) begin
                    if (top_level_a64_i && !top_level_enable_i) begin
                        dec_trap3 = 1'b1;
                    end else if (!top_level_a64_i &&
                        !monitor_sysreg_enable_reg_i[`CISE_HSRE_EN]) begin
                        dec_undef = 1'b1;
                    end
                end
            end
            `CISE_ENC_EL1SRE: begin
                if (req_level_q == `CISE_LVL_EL0) begin
                    dec_undef = 1'b1;
                end else if (ns_el1 && !en_eff) begin
                    dec_trap2 = 1'b1;
                end
            end
            `CISE_ENC_IAR0: begin
                if (req_level_q == `CISE_LVL_EL0) begin
                    dec_undef = 1'b1;
                end else if (req_level_q == `CISE_LVL_EL1) begin
                    if (!el1_sysreg_enable_reg_i[`CISE_HSRE_SRE]) begin
                        dec_undef = 1'b1;
                    end else if (ns_el1 && hyp_coproc_trap_ctl_i) begin
                        dec_trap2 = 1'b1;
                    end else if (ns_el1 && trap_all_group0_ctl_i) begin
                        dec_trap2 = 1'b1;
                    end else if (HAS_EL3 != 0 && monitor_fiq_route_ctl_i &&
                        !hyp_fiq_route_ctl_i && req_ns_q) begin
                        dec_undef = a32_top;
                        dec_trap3 = !a32_top;
                    end else if (HAS_EL3 != 0 && monitor_fiq_route_ctl_i &&
                        !req_ns_q && !a32_top) begin
                        dec_trap3 = 1'b1;
                    end else if (ns_el1 && hyp_fiq_route_ctl_i) begin
                        dec_virt = 1'b1;
                    end
                end else if (req_level_q == `CISE_LVL_EL2) begin
                    if (!sre_rd) begin
                        dec_undef = 1'b1;
                    end else if (HAS_EL3 != 0 && monitor_fiq_route_ctl_i) begin
                        dec_undef = a32_top;
                        dec_trap3 = !a32_top;
                    end
                end else begin
                    if (!monitor_sysreg_enable_reg_i[`CISE_HSRE_SRE]) begin
                        dec_undef = 1'b1;
                    end else if (a32_top && monitor_fiq_route_ctl_i && !req_mon_q) begin
                        dec_undef = 1'b1;
                    end
                end
            end
            default: begin
                dec_undef = 1'b1;
            end
        endcase
    end

    wire dec_ok;
    wire iar_take;
    wire hsre_wr;
    wire [`CISE_ID_W-1:0] iar_id;

    assign dec_ok = !dec_undef && !dec_trap2 && !dec_trap3;
    // Writes through the ack encoding change nothing
    assign iar_take = (state_q == S_EVAL) && dec_ok && !dec_virt && !req_write_q &&
        (req_enc_q == `CISE_ENC_IAR0);
    assign hsre_wr = (state_q == S_EVAL) && dec_ok && req_write_q &&
        (req_enc_q == `CISE_ENC_HSRE);
    assign iar_id = pend_valid_i ? pend_id_i :
        (pend_why_i == `CISE_WHY_SEC) ? `CISE_ID_SPUR_SEC :
        (pend_why_i == `CISE_WHY_NS) ? `CISE_ID_SPUR_NS :
        `CISE_ID_SPUR;

    // ------------------------------------------------------------------
    // Acknowledge word
    // ------------------------------------------------------------------
    wire [31:0] iar_word;

    cise_ack_fmt #(
        .ID_BITS(ID_BITS)
    ) u_fmt (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(iar_take),
        .id_i(iar_id),
        .word_q(iar_word)
    );

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    always @* begin
        state_d = state_q;
        case (state_q)
            S_IDLE: begin
                if (req_i) begin
                    state_d = S_EVAL;
                end
            end
            S_EVAL: begin
                state_d = iar_take ? S_SYNC : S_RESP;
            end
            S_SYNC: begin
                if (sync_cnt_q == 2'h0) begin
                    state_d = S_RESP;
                end
            end
            S_RESP: begin
                state_d = S_IDLE;
            end
            default: begin
                state_d = S_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q <= S_IDLE;
            req_write_q <= 1'b0;
            req_enc_q <= `CISE_ENC_NONE;
            req_level_q <= `CISE_LVL_EL0;
            req_ns_q <= 1'b0;
            req_mon_q <= 1'b0;
            req_wdata_q <= 32'h00000000;
            sync_cnt_q <= 2'h0;
        end else begin
            state_q <= state_d;
            if (state_q == S_IDLE && req_i) begin
                req_write_q <= req_write_i;
                req_enc_q <= req_enc_i;
                req_level_q <= req_level_i;
                req_ns_q <= req_nonsecure_i;
                req_mon_q <= req_monitor_mode_i;
                req_wdata_q <= req_wdata_i;
            end
            // Masked reads wait until activation shows on the lines
            if (iar_take) begin
                sync_cnt_q <= pe_irq_masked_i ? `CISE_SYNC_MASKED : `CISE_SYNC_OPEN;
            end else if (sync_cnt_q != 2'h0) begin
                sync_cnt_q <= sync_cnt_q - 2'h1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Hypervisor enable register
    // ------------------------------------------------------------------
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hsre_q <= `CISE_HSRE_RST;
            mon_bypass_we_o <= 1'b0;
            mon_bypass_wdata_o <= 2'h0;
        end else begin
            mon_bypass_we_o <= 1'b0;
            if (hsre_wr) begin
                hsre_q[`CISE_HSRE_EN] <= req_wdata_q[`CISE_HSRE_EN];
                if (SRE_ONLY == 0) begin
                    hsre_q[`CISE_HSRE_SRE] <= req_wdata_q[`CISE_HSRE_SRE];
                end
                if (HAS_EL3 == 0) begin
                    if (IRQ_BYPASS != 0) begin
                        hsre_q[`CISE_HSRE_DIB] <= req_wdata_q[`CISE_HSRE_DIB];
                    end
                    if (FIQ_BYPASS != 0) begin
                        hsre_q[`CISE_HSRE_DFB] <= req_wdata_q[`CISE_HSRE_DFB];
                    end
                end else if (security_disable_ctl_i) begin
                    mon_bypass_we_o <= 1'b1;
                    mon_bypass_wdata_o <= {
                        (IRQ_BYPASS != 0) ? req_wdata_q[`CISE_HSRE_DIB] : dib_rd,
                        (FIQ_BYPASS != 0) ? req_wdata_q[`CISE_HSRE_DFB] : dfb_rd};
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            req_ready_o <= 1'b0;
            resp_valid_o <= 1'b0;
            resp_rdata_o <= 32'h00000000;
            resp_undef_o <= 1'b0;
            resp_trap_el2_o <= 1'b0;
            resp_trap_el3_o <= 1'b0;
            resp_virtual_o <= 1'b0;
            ack_o <= 1'b0;
            ack_id_o <= {`CISE_ID_W{1'b0}};
            irq_bypass_disable_o <= 1'b0;
            fiq_bypass_disable_o <= 1'b0;
            sysreg_interface_select_o <= 1'b0;
            el1_enable_trap_o <= 1'b0;
        end else begin
            req_ready_o <= (state_d == S_IDLE);
            resp_valid_o <= (state_d == S_RESP);
            ack_o <= iar_take && pend_valid_i;
            if (iar_take) begin
                ack_id_o <= iar_id;
            end
            if (state_q == S_EVAL) begin
                resp_undef_o <= dec_undef;
                resp_trap_el2_o <= dec_trap2;
                resp_trap_el3_o <= dec_trap3;
                resp_virtual_o <= dec_virt && dec_ok;
                resp_rdata_o <= 32'h00000000;
                if (dec_ok && !req_write_q) begin
                    if (req_enc_q == `CISE_ENC_HSRE) begin
                        resp_rdata_o <= hsre_rd;
                    end else if (req_enc_q == `CISE_ENC_EL1SRE) begin
                        resp_rdata_o <= {28'h0000000, el1_sysreg_enable_reg_i};
                    end
                end
            end else if (state_q == S_SYNC && state_d == S_RESP) begin
                resp_rdata_o <= iar_word;
            end
            irq_bypass_disable_o <= dib_rd;
            fiq_bypass_disable_o <= dfb_rd;
            sysreg_interface_select_o <= sre_rd;
            el1_enable_trap_o <= ~en_eff;
        end
    end

endmodule

//--- tb/cise_top_chk.sv
// Assertion checker for the sysreg enable and group 0 ack block
`timescale 1ns/1ps
`include "cise_map.vh"
module cise_top_chk #(
    parameter HAS_EL3 = 1,
    parameter IRQ_BYPASS = 1,
    parameter FIQ_BYPASS = 1,
    parameter SRE_ONLY = 0,
    parameter ID_BITS = 24
) (
    // Clock, reset and watched inputs
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire pe_irq_masked_i,
    input wire security_disable_ctl_i,
    // Watched outputs
    input wire req_ready_o,
    input wire resp_valid_o,
    input wire [31:0] resp_rdata_o,
    input wire resp_undef_o,
    input wire resp_trap_el2_o,
    input wire resp_trap_el3_o,
    input wire resp_virtual_o,
    input wire ack_o,
    input wire [`CISE_ID_W-1:0] ack_id_o,
    input wire mon_bypass_we_o,
    input wire irq_bypass_disable_o,
    input wire fiq_bypass_disable_o,
    input wire sysreg_interface_select_o
);
    wire refused = resp_undef_o | resp_trap_el2_o | resp_trap_el3_o | resp_virtual_o;

    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Gap from acknowledge to answer
    sequence open_gap;
        !resp_valid_o [*2] ##1 resp_valid_o;
    endsequence
    sequence masked_gap;
        !resp_valid_o [*3] ##1 resp_valid_o;
    endsequence

    ack_open_a: assert property (ack_o && !$past(pe_irq_masked_i) |-> open_gap)
        else $error("ack answer timing wrong while unmasked");
    ack_masked_a: assert property (ack_o && $past(pe_irq_masked_i) |-> masked_gap)
        else $error("ack answer timing wrong while masked");
    ack_data_a: assert property (ack_o |-> ##[2:3] (resp_valid_o && !refused &&
        resp_rdata_o[15:0] == ack_id_o[15:0])) else $error("ack id not returned");
    rsvd_zero_a: assert property (resp_valid_o |-> resp_rdata_o[31:24] == 8'h00)
        else $error("reserved read bits not zero");
    id_narrow_a: assert property (resp_valid_o && ID_BITS == 16 |-> resp_rdata_o[23:16] == 8'h00)
        else $error("unimplemented id bits not zero");
    refused_data_a: assert property (resp_valid_o && refused |-> resp_rdata_o == 32'h0)
        else $error("refused access returned data");
    one_flag_a: assert property (resp_valid_o |-> $onehot0({resp_undef_o, resp_trap_el2_o,
        resp_trap_el3_o, resp_virtual_o})) else $error("several refusal flags at once");
    mon_fwd_a: assert property (mon_bypass_we_o |->
        resp_valid_o && $past(security_disable_ctl_i) && HAS_EL3 != 0)
        else $error("monitor copy written while read-only");
    irq_rao_a: assert property (IRQ_BYPASS == 0 && $past(rst_n_i) |-> irq_bypass_disable_o)
        else $error("irq bypass disable not one");
    fiq_rao_a: assert property (FIQ_BYPASS == 0 && $past(rst_n_i) |-> fiq_bypass_disable_o)
        else $error("fiq bypass disable not one");
    sel_rao_a: assert property (SRE_ONLY != 0 && $past(rst_n_i) |-> sysreg_interface_select_o)
        else $error("select not one in sysreg-only build");
    busy_bound_a: assert property ($fell(req_ready_o) |-> ##[1:4] resp_valid_o)
        else $error("no answer within bound");
endmodule

//--- tb/cise_core_mdl.sv
// Core model issuing one register access at a time
`timescale 1ns/1ps
module cise_core_mdl (
    // Clock, reset and answer
    input wire ref_clk_i,
    input wire rst_n_i,
    input wire req_ready_i,
    input wire resp_valid_i,
    // Request
    output logic req_o = 1'b0,
    output logic req_write_o = 1'b0,
    output logic [1:0] req_enc_o = 2'h0,
    output logic [1:0] req_level_o = 2'h0,
    output logic req_nonsecure_o = 1'b0,
    output logic req_monitor_mode_o = 1'b0,
    output logic [31:0] req_wdata_o = 32'h0
);
    int lat = 0;

    // Held to the take edge, then fields scrambled
    task automatic access(input logic w, input logic [1:0] enc, input logic [1:0] lvl,
        input logic ns, input logic mon, input logic [31:0] wd);
        int n;
        lat = 0;
        for (n = 0; n < 20 && req_ready_i !== 1'b1; n++) begin
            @(posedge ref_clk_i);
            #1;
        end
        @(posedge ref_clk_i);
        {req_o, req_write_o, req_enc_o, req_level_o, req_nonsecure_o, req_monitor_mode_o,
            req_wdata_o} <= {1'b1, w, enc, lvl, ns, mon, wd};
        @(posedge ref_clk_i);
        {req_o, req_write_o, req_enc_o, req_level_o, req_nonsecure_o, req_monitor_mode_o,
            req_wdata_o} <= {1'b0, ~w, ~enc, ~lvl, ~ns, ~mon, ~wd};
        // Nothing new issued before the answer
        for (n = 1; n <= 10 && lat == 0; n++) begin
            @(posedge ref_clk_i);
            #1;
            if (resp_valid_i === 1'b1) lat = n + 1;
        end
    endtask
endmodule

//--- tb/cise_top_tb_top.sv
// Self-checking testbench for the sysreg enable and group 0 ack block
`timescale 1ns/1ps
`include "cise_map.vh"
module cise_top_tb_top;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, pe_irq_masked_i = 1'b0, top_level_a64_i = 1'b0;
    logic security_disable_ctl_i = 1'b0, hyp_fiq_route_ctl_i = 1'b0, hyp_coproc_trap_ctl_i = 1'b0;
    logic trap_all_group0_ctl_i = 1'b0, monitor_fiq_route_ctl_i = 1'b0, top_level_enable_i = 1'b1;
    logic [3:0] monitor_sysreg_enable_reg_i = 4'h9, el1_sysreg_enable_reg_i = 4'h1;
    logic pend_valid_i = 1'b0;
    logic [1:0] pend_why_i = 2'h0;
    logic [`CISE_ID_W-1:0] pend_id_i = 24'h0;
    wire req_i, req_write_i, req_nonsecure_i, req_monitor_mode_i, req_ready_o, resp_valid_o;
    wire [1:0] req_enc_i, req_level_i, mon_bypass_wdata_o;
    wire [31:0] req_wdata_i, resp_rdata_o;
    wire resp_undef_o, resp_trap_el2_o, resp_trap_el3_o, resp_virtual_o, ack_o, mon_bypass_we_o;
    wire irq_bypass_disable_o, fiq_bypass_disable_o, sysreg_interface_select_o, el1_enable_trap_o;
    wire [`CISE_ID_W-1:0] ack_id_o;
    int err_total = 0, n_compared = 0, acks = 0;

    initial forever #5 ref_clk_i = ~ref_clk_i;

    cise_top #(.HAS_EL3(1), .IRQ_BYPASS(1), .FIQ_BYPASS(0), .SRE_ONLY(0), .ID_BITS(16)) cise_top_i (
        .ref_clk_i, .rst_n_i, .req_i, .req_write_i, .req_enc_i, .req_level_i, .req_nonsecure_i,
        .req_monitor_mode_i, .req_wdata_i, .pe_irq_masked_i, .top_level_a64_i,
        .security_disable_ctl_i, .hyp_fiq_route_ctl_i, .hyp_coproc_trap_ctl_i,
        .trap_all_group0_ctl_i, .monitor_fiq_route_ctl_i, .monitor_sysreg_enable_reg_i,
        .top_level_enable_i, .el1_sysreg_enable_reg_i, .pend_valid_i, .pend_why_i, .pend_id_i,
        .req_ready_o, .resp_valid_o, .resp_rdata_o, .resp_undef_o, .resp_trap_el2_o,
        .resp_trap_el3_o, .resp_virtual_o, .ack_o, .ack_id_o, .mon_bypass_we_o,
        .mon_bypass_wdata_o, .irq_bypass_disable_o, .fiq_bypass_disable_o,
        .sysreg_interface_select_o, .el1_enable_trap_o);

    cise_core_mdl cise_core_mdl_i (.ref_clk_i, .rst_n_i, .req_ready_i(req_ready_o),
        .resp_valid_i(resp_valid_o), .req_o(req_i), .req_write_o(req_write_i),
        .req_enc_o(req_enc_i), .req_level_o(req_level_i), .req_nonsecure_o(req_nonsecure_i),
        .req_monitor_mode_o(req_monitor_mode_i), .req_wdata_o(req_wdata_i));

    // Monitor copy lives here, outside the block
    always @(posedge ref_clk_i) begin
        if (ack_o === 1'b1) acks <= acks + 1;
        if (mon_bypass_we_o === 1'b1) monitor_sysreg_enable_reg_i[2:1] <= mon_bypass_wdata_o;
    end

    task automatic close_out;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic acc(input logic w, input logic [1:0] enc, input logic [1:0] lvl,
        input logic ns, input logic [31:0] wd, input logic [3:0] flg, input logic [31:0] data,
        input int lat);
        int a0;
        a0 = acks;
        cise_core_mdl_i.access(w, enc, lvl, ns, lvl == `CISE_LVL_EL3, wd);
        if (cise_core_mdl_i.lat == 0) begin
            err_total++;
            $display("MISMATCH answer expected 1 seen 0");
            close_out;
        end
        chk("flags", {28'h0, flg}, {28'h0, resp_undef_o, resp_trap_el2_o, resp_trap_el3_o,
            resp_virtual_o});
        chk("rdata", data, resp_rdata_o);
        chk("latency", lat, cise_core_mdl_i.lat);
        chk("acks", lat >= 4 && pend_valid_i, acks - a0);
        @(posedge ref_clk_i);
        #1;
    endtask

    task automatic t_reset;
        chk("fiq view", 1, fiq_bypass_disable_o);
        chk("irq view", 0, irq_bypass_disable_o);
        chk("select", 0, sysreg_interface_select_o);
        acc(0, `CISE_ENC_HSRE, `CISE_LVL_EL2, 1, 0, 4'h0, 32'h2, 2);
        $display("t_reset done");
    endtask

    task automatic t_alias;
        acc(1, `CISE_ENC_HSRE, `CISE_LVL_EL2, 1, 32'h7, 4'h0, 0, 2);
        chk("irq kept", 0, irq_bypass_disable_o);
        chk("select", 1, sysreg_interface_select_o);
        chk("fiq kept", 1, fiq_bypass_disable_o);
        @(posedge ref_clk_i);
        security_disable_ctl_i <= 1'b1;
        // Select stays one from here on
        acc(1, `CISE_ENC_HSRE, `CISE_LVL_EL2, 1, 32'h5, 4'h0, 0, 2);
        repeat (3) @(posedge ref_clk_i);
        #1;
        chk("irq set", 1, irq_bypass_disable_o);
        acc(0, `CISE_ENC_HSRE, `CISE_LVL_EL2, 1, 0, 4'h0, 32'h7, 2);
        $display("t_alias done");
    endtask

    task automatic t_hyp_traps;
        @(posedge ref_clk_i);
        monitor_sysreg_enable_reg_i[3] <= 1'b0;
        acc(0, `CISE_ENC_HSRE, `CISE_LVL_EL2, 1, 0, 4'h8, 0, 2);
        @(posedge ref_clk_i);
        monitor_sysreg_enable_reg_i[3] <= 1'b1;
        top_level_a64_i <= 1'b1;
        top_level_enable_i <= 1'b0;
        acc(0, `CISE_ENC_HSRE, `CISE_LVL_EL2, 1, 0, 4'h2, 0, 2);
        @(posedge ref_clk_i);
        top_level_a64_i <= 1'b0;
        top_level_enable_i <= 1'b1;
        hyp_coproc_trap_ctl_i <= 1'b1;
        acc(0, `CISE_ENC_HSRE, `CISE_LVL_EL1, 1, 0, 4'h4, 0, 2);
        @(posedge ref_clk_i);
        hyp_coproc_trap_ctl_i <= 1'b0;
        acc(1, `CISE_ENC_HSRE, `CISE_LVL_EL2, 1, 32'h1, 4'h0, 0, 2);
        chk("el1 trap on", 1, el1_enable_trap_o);
        acc(0, `CISE_ENC_EL1SRE, `CISE_LVL_EL1, 1, 0, 4'h4, 0, 2);
        acc(1, `CISE_ENC_HSRE, `CISE_LVL_EL2, 1, 32'h9, 4'h0, 0, 2);
        chk("el1 trap off", 0, el1_enable_trap_o);
        acc(0, `CISE_ENC_EL1SRE, `CISE_LVL_EL1, 1, 0, 4'h0, 32'h1, 2);
        $display("t_hyp_traps done");
    endtask

    task automatic t_ack;
        @(posedge ref_clk_i);
        pend_valid_i <= 1'b1;
        pend_id_i <= 24'habcdef;
        acc(0, `CISE_ENC_IAR0, `CISE_LVL_EL3, 0, 0, 4'h0, 32'h0000cdef, 4);
        acc(1, `CISE_ENC_IAR0, `CISE_LVL_EL3, 0, 32'hffffffff, 4'h0, 0, 2);
        @(posedge ref_clk_i);
        pe_irq_masked_i <= 1'b1;
        acc(0, `CISE_ENC_IAR0, `CISE_LVL_EL2, 1, 0, 4'h0, 32'h0000cdef, 5);
        @(posedge ref_clk_i);
        pe_irq_masked_i <= 1'b0;
        pend_valid_i <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            @(posedge ref_clk_i);
            pend_why_i <= (k == 2) ? 2'h0 : k[1:0] + 2'h1;
            acc(0, `CISE_ENC_IAR0, `CISE_LVL_EL3, 0, 0, 4'h0, (k == 2) ? 1023 : 1020 + k, 4);
        end
        $display("t_ack done");
    endtask

    task automatic t_ack_refused;
        @(posedge ref_clk_i);
        el1_sysreg_enable_reg_i <= 4'h0;
        acc(0, `CISE_ENC_IAR0, `CISE_LVL_EL1, 0, 0, 4'h8, 0, 2);
        @(posedge ref_clk_i);
        el1_sysreg_enable_reg_i <= 4'h1;
        trap_all_group0_ctl_i <= 1'b1;
        acc(0, `CISE_ENC_IAR0, `CISE_LVL_EL1, 1, 0, 4'h4, 0, 2);
        @(posedge ref_clk_i);
        trap_all_group0_ctl_i <= 1'b0;
        hyp_fiq_route_ctl_i <= 1'b1;
        acc(0, `CISE_ENC_IAR0, `CISE_LVL_EL1, 1, 0, 4'h1, 0, 2);
        @(posedge ref_clk_i);
        hyp_fiq_route_ctl_i <= 1'b0;
        monitor_fiq_route_ctl_i <= 1'b1;
        acc(0, `CISE_ENC_IAR0, `CISE_LVL_EL2, 1, 0, 4'h8, 0, 2);
        @(posedge ref_clk_i);
        top_level_a64_i <= 1'b1;
        acc(0, `CISE_ENC_IAR0, `CISE_LVL_EL2, 1, 0, 4'h2, 0, 2);
        acc(0, `CISE_ENC_NONE, `CISE_LVL_EL2, 1, 0, 4'h8, 0, 2);
        $display("t_ack_refused done");
    endtask

    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        #1;
        t_reset;
        t_alias;
        t_hyp_traps;
        t_ack;
        t_ack_refused;
        close_out;
    end
endmodule

bind cise_top cise_top_chk #(.HAS_EL3(HAS_EL3), .IRQ_BYPASS(IRQ_BYPASS),
    .FIQ_BYPASS(FIQ_BYPASS), .SRE_ONLY(SRE_ONLY), .ID_BITS(ID_BITS)) cise_top_chk_i (
    .ref_clk_i, .rst_n_i, .pe_irq_masked_i, .security_disable_ctl_i, .req_ready_o,
    .resp_valid_o, .resp_rdata_o, .resp_undef_o, .resp_trap_el2_o, .resp_trap_el3_o,
    .resp_virtual_o, .ack_o, .ack_id_o, .mon_bypass_we_o, .irq_bypass_disable_o,
    .fiq_bypass_disable_o, .sysreg_interface_select_o);
